// File: hw/sss_top.sv
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "sss_map.svh"

module sss_top
   import sss_pkg::*;
#(
   parameter logic [31:0] CLK_HZ = `SSS_CLK_HZ,
   parameter logic [31:0] BIT_HZ = `SSS_BIT_HZ
)(
   input  wire logic      clk,
   input  wire logic      reset_n,
   input  wire logic [7:0] reg_addr,
   input  wire sss_word_t reg_wdata,
   input  wire logic      reg_wr,
   input  wire logic      reg_rd,
   output sss_word_t      reg_rdata,
   output logic           sample_request_irq_n,
   output logic           irq,
   output sss_link_s      dac
);

   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   // The bit clock toggles at most once per system clock cycle
   if ((BIT_HZ * 2) > CLK_HZ) begin : g_bad_bit_rate
      $error("Bit clock too fast for system clock");
   end
   if ((`SSS_RATE_HIGH_HZ * 64) > BIT_HZ) begin : g_bad_word_rate
      $error("Bit clock too slow for 32 bits per word");
   end

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_meta_r;
   logic rst_n_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   logic wr_sample;
   logic wr_ctrl;
   logic wr_clr;
   logic wr_en;

   assign wr_sample = reg_wr && (reg_addr == `SSS_OFF_SAMPLE);
   assign wr_ctrl   = reg_wr && (reg_addr == `SSS_OFF_CTRL);
   assign wr_clr    = reg_wr && (reg_addr == `SSS_OFF_IRQ_CLR);
   assign wr_en     = reg_wr && (reg_addr == `SSS_OFF_IRQ_EN);

   // ----------------------------------------
   // Sample and control registers
   // ----------------------------------------
   sss_word_t sample_r;
   sss_ctrl_s ctrl_r;
   logic      fresh_r;
   logic      period_start;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sample_r <= `SSS_RST_SAMPLE;
      end else if (wr_sample) begin
         sample_r <= reg_wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_r <= `SSS_RST_CTRL;
      end else if (wr_ctrl) begin
         ctrl_r <= reg_wdata[3:0];
      end
   end

   // Marks that the host refilled the buffer since the last period
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         fresh_r <= 1'b0;
      end else if (wr_sample) begin
         fresh_r <= 1'b1;
      end else if (period_start) begin
         fresh_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // Word rate select
   // ----------------------------------------
   logic [31:0] rate_hz;

   always_comb begin
      if (ctrl_r.rate_high_select) begin
         rate_hz = `SSS_RATE_HIGH_HZ;
      end else if (ctrl_r.rate_mid_select) begin
         rate_hz = `SSS_RATE_MID_HZ;
      end else if (ctrl_r.rate_low_select) begin
         rate_hz = `SSS_RATE_LOW_HZ;
      end else begin
         rate_hz = `SSS_RATE_BASE_HZ;
      end
   end

   // ----------------------------------------
   // Bit clock generator
   // ----------------------------------------
   // Fractional accumulator keeps the average rate exact even though
   // the system clock is not a whole multiple of the bit clock
   logic [32:0] bit_acc_r;
   logic [32:0] bit_sum;
   logic        bit_tick;
   logic        bclk_r;
   logic        bit_fall;

   assign bit_sum  = bit_acc_r + {BIT_HZ, 1'b0};
   assign bit_tick = bit_sum >= {1'b0, CLK_HZ};
   assign bit_fall = bit_tick && bclk_r;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         bit_acc_r <= 33'h0_0000_0000;
      end else if (bit_tick) begin
         bit_acc_r <= bit_sum - {1'b0, CLK_HZ};
      end else begin
         bit_acc_r <= bit_sum;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         bclk_r <= 1'b0;
      end else if (bit_tick) begin
         bclk_r <= ~bclk_r;
      end
   end

   // ----------------------------------------
   // Word clock generator
   // ----------------------------------------
   logic [32:0] word_acc_r;
   logic [32:0] word_sum;
   logic        word_tick;
   logic        ws_pend_r;
   sss_phase_e  phase_r;
   logic        phase_flip;

   assign word_sum   = word_acc_r + {rate_hz, 1'b0};
   assign word_tick  = word_sum >= {1'b0, CLK_HZ};
   assign phase_flip = bit_fall && ws_pend_r;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         word_acc_r <= 33'h0_0000_0000;
      end else if (!ctrl_r.output_enable_bit) begin
         word_acc_r <= 33'h0_0000_0000;
      end else if (word_tick) begin
         word_acc_r <= word_sum - {1'b0, CLK_HZ};
      end else begin
         word_acc_r <= word_sum;
      end
   end

   // Half-period ticks wait for a bit clock falling edge
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ws_pend_r <= 1'b0;
      end else if (!ctrl_r.output_enable_bit) begin
         ws_pend_r <= 1'b0;
      end else if (word_tick) begin
         ws_pend_r <= 1'b1;
      end else if (phase_flip) begin
         ws_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         phase_r <= SSS_PHASE_LEFT;
      end else if (!ctrl_r.output_enable_bit) begin
         phase_r <= SSS_PHASE_LEFT;
      end else if (phase_flip) begin
         case (phase_r)
            SSS_PHASE_LEFT:  phase_r <= SSS_PHASE_RIGHT;
            SSS_PHASE_RIGHT: phase_r <= SSS_PHASE_LEFT;
            default:         phase_r <= SSS_PHASE_LEFT;
         endcase
      end
   end

   // A new period opens when the word clock returns to the left phase
   assign period_start = phase_flip && (phase_r == SSS_PHASE_RIGHT);

   // ----------------------------------------
   // Parallel to serial
   // ----------------------------------------
   sss_word_t   frame_r;
   logic [15:0] shift_r;

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         frame_r <= `SSS_RST_SAMPLE;
      end else if (period_start) begin
         frame_r <= sample_r;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         shift_r <= 16'h0000;
      end else if (!ctrl_r.output_enable_bit) begin
         shift_r <= 16'h0000;
      end else if (period_start) begin
         shift_r <= sample_r[`SSS_LEFT_MSB -: 16];
      end else if (phase_flip) begin
         shift_r <= frame_r[`SSS_RIGHT_MSB -: 16];
      end else if (bit_fall) begin
         shift_r <= {shift_r[14:0], 1'b0};
      end
   end

   // Link outputs all come straight from flip-flops
   assign dac.bit_clock         = bclk_r;
   assign dac.word_select_clock = (phase_r == SSS_PHASE_RIGHT);
   assign dac.serial_data       = shift_r[15];

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   logic [1:0] events;
   logic [1:0] stat_r;
   logic [1:0] ien_r;
   logic [1:0] clr_mask;

   assign events[`SSS_EV_REQUEST]  = period_start;
   assign events[`SSS_EV_UNDERRUN] = period_start && !fresh_r;

   always_comb begin
      clr_mask = 2'h0;
      if (wr_clr) begin
         clr_mask = reg_wdata[1:0];
      end
      if (wr_sample) begin
         clr_mask[`SSS_EV_REQUEST] = 1'b1;
      end
   end

   // A new event in the clearing cycle survives the clear
   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         stat_r <= `SSS_RST_EVENTS;
      end else begin
         stat_r <= (stat_r & ~clr_mask) | events;
      end
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ien_r <= `SSS_RST_EVENTS;
      end else if (wr_en) begin
         ien_r <= reg_wdata[1:0];
      end
   end

   assign sample_request_irq_n = ~stat_r[`SSS_EV_REQUEST];
   assign irq                  = |(stat_r & ien_r);

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   sss_word_t rdata_r;
   sss_word_t rd_mux;

   // Sample register is write-only and unmapped addresses read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (reg_addr)
         `SSS_OFF_CTRL:     rd_mux[3:0] = ctrl_r;
         `SSS_OFF_IRQ_STAT: rd_mux[1:0] = stat_r;
         `SSS_OFF_IRQ_EN:   rd_mux[1:0] = ien_r;
         default:           rd_mux      = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata_r <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_r <= rd_mux;
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_r;

endmodule // sss_top

// File: hw/sss_map.svh
// Behaviour
// - One 32-bit word carries a 16-bit left and 16-bit right sample.
// - Bit clock of 7.5 MHz and rate-selected word clock come from system clock.
// - One sample request is raised per word-clock period, in step with it.
// - Buffered word is shifted out one bit per bit clock, channels merged.
// - Sample register is 32-bit write-only, reset zero; writing it clears request.
// - Control register holds four bits D3..D0, zero at reset; D31..D4 unused.
// - Control bit D0 off stops the word clock and playback.
// - Rates 8k, 11.025k, 22.05k, 44.1k; higher rate bit wins.
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SSS_OFF_SAMPLE     8'h00
`define SSS_OFF_CTRL       8'h04
`define SSS_OFF_IRQ_STAT   8'h08
`define SSS_OFF_IRQ_CLR    8'h0C
`define SSS_OFF_IRQ_EN     8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SSS_BIT_ENABLE     0
`define SSS_BIT_RATE_HIGH  1
`define SSS_BIT_RATE_MID   2
`define SSS_BIT_RATE_LOW   3
`define SSS_EV_REQUEST     0
`define SSS_EV_UNDERRUN    1
`define SSS_LEFT_MSB       31
`define SSS_RIGHT_MSB      15

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SSS_RST_SAMPLE     32'h0000_0000
`define SSS_RST_CTRL       4'h0
`define SSS_RST_EVENTS     2'h0

// ----------------------------------------
// Timing in Hz
// ----------------------------------------
`define SSS_CLK_HZ         32'h017D_7840
`define SSS_BIT_HZ         32'h0072_70E0
`define SSS_RATE_BASE_HZ   32'h0000_1F40
`define SSS_RATE_LOW_HZ    32'h0000_2B11
`define SSS_RATE_MID_HZ    32'h0000_5622
`define SSS_RATE_HIGH_HZ   32'h0000_AC44

`endif

// File: hw/sss_pkg.sv
package sss_pkg;

   // ----------------------------------------
   // Shared types
   // ----------------------------------------
   typedef logic [31:0] sss_word_t;

   typedef enum logic {
      SSS_PHASE_LEFT,
      SSS_PHASE_RIGHT
   } sss_phase_e;

   typedef struct packed {
      logic bit_clock;
      logic word_select_clock;
      logic serial_data;
   } sss_link_s;

   typedef struct packed {
      logic       rate_low_select;
      logic       rate_mid_select;
      logic       rate_high_select;
      logic       output_enable_bit;
   } sss_ctrl_s;

endpackage

// File: sim/sss_top_properties.sv
`timescale 1ns/1ps
`include "sss_map.svh"

module sss_top_properties
   import sss_pkg::*;
#(
   parameter logic [31:0] CLK_HZ = `SSS_CLK_HZ,
   parameter logic [31:0] BIT_HZ = `SSS_BIT_HZ
)(
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic [7:0] reg_addr,
   input wire sss_word_t  reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire sss_word_t  reg_rdata,
   input wire logic       sample_request_irq_n,
   input wire logic       irq,
   input wire sss_link_s  dac
);
   logic [3:0]  ctl_r;
   logic [1:0]  flips_r;
   logic [15:0] cnt_r;
   logic        ws_q;
   logic        ws;
   int          half;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   assign ws = dac.word_select_clock;
   // Highest rate bit wins
   always_comb begin
      half = int'(CLK_HZ) / (2 * (ctl_r[1] ? `SSS_RATE_HIGH_HZ : ctl_r[2] ? `SSS_RATE_MID_HZ :
                                  ctl_r[3] ? `SSS_RATE_LOW_HZ : `SSS_RATE_BASE_HZ));
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_r <= 4'h0;
      end else if (reg_wr && reg_addr == `SSS_OFF_CTRL) begin
         ctl_r <= reg_wdata[3:0];
      end
   end
   // Half periods are trusted only after three flips since the last rate write
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ws_q <= 1'b0;
         cnt_r <= 16'h0000;
         flips_r <= 2'h0;
      end else begin
         ws_q <= ws;
         cnt_r <= (ws != ws_q) ? 16'h0001 : cnt_r + 16'h0001;
         if (reg_wr && reg_addr == `SSS_OFF_CTRL) begin
            flips_r <= 2'h0;
         end else if (ws != ws_q && flips_r != 2'h3) begin
            flips_r <= flips_r + 2'h1;
         end
      end
   end

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_sample_read_zero:
      assert property (reg_rd && reg_addr == `SSS_OFF_SAMPLE |=> reg_rdata == 32'h0000_0000)
      else $error("sample register readable");
   a_ctrl_upper_zero:
      assert property (reg_rd && reg_addr == `SSS_OFF_CTRL |=> reg_rdata[31:4] == 28'h000_0000)
      else $error("control upper bits nonzero");
   a_disabled_quiet:
      assert property (!ctl_r[0] [*4] |-> !ws && !dac.serial_data)
      else $error("link active while disabled");
   a_ws_on_bitfall:
      assert property (ctl_r[0] && $past(ctl_r[0]) && $changed(ws) |-> $fell(dac.bit_clock))
      else $error("word clock moved off a bit clock fall");
   a_bitclk_halves:
      assert property ($changed(dac.bit_clock) |=> ##[0:1] $changed(dac.bit_clock))
      else $error("bit clock half too long");
   // Turning output off returns the word clock to left with no request, so only enabled falls count
   a_request_on_left:
      assert property (ctl_r[0] && $fell(ws) |-> ##[0:1] !sample_request_irq_n)
      else $error("no request at left phase start");
   a_write_clears_req:
      assert property (reg_wr && reg_addr == `SSS_OFF_SAMPLE |-> ##[1:2] sample_request_irq_n)
      else $error("sample write left request pending");
   a_ws_half_period:
      assert property (ws != ws_q && flips_r == 2'h3 |-> cnt_r + 6 >= half && cnt_r <= half + 6)
      else $error("word clock half period off rate");

   c_left_start: cover property ($fell(ws));
   c_request: cover property ($fell(sample_request_irq_n));
   c_irq: cover property ($rose(irq));
endmodule // sss_top_properties

// File: sim/sss_dac_model.sv
`timescale 1ns/1ps

module sss_dac_model
   import sss_pkg::*;
(
   input  wire logic      clk,
   input  wire sss_link_s dac,
   output logic [15:0]    left_word,
   output logic [15:0]    right_word
);
   logic        bclk_q = 1'b0;
   logic        ws_q = 1'b0;
   logic [15:0] sh = 16'h0000;
   int          nbits = 0;

   initial begin
      left_word = 16'h0000;
      right_word = 16'h0000;
   end
   always @(posedge clk) begin
      if (dac.word_select_clock != ws_q) begin
         if (ws_q) right_word = sh;
         else left_word = sh;
         nbits = 0;
      end
      // Padding after sixteen bits is ignored
      if (dac.bit_clock && !bclk_q && nbits < 16) begin
         sh = {sh[14:0], dac.serial_data};
         nbits++;
      end
      bclk_q = dac.bit_clock;
      ws_q = dac.word_select_clock;
   end
endmodule // sss_dac_model

// File: sim/tb.sv
`timescale 1ns/1ps
`include "sss_map.svh"

module tb
   import sss_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset_n;
   logic [7:0]  reg_addr;
   sss_word_t   reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   sss_word_t   reg_rdata;
   logic        sample_request_irq_n;
   logic        irq;
   sss_link_s   dac;
   logic [15:0] left_word;
   logic [15:0] right_word;
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          seed = 32'hed30_d00b;
   int          n_req = 0;
   sss_word_t   w1 = 32'h0000_0000;
   sss_word_t   w2 = 32'h0000_0000;
   sss_word_t   rv;
   logic [3:0]  rates [5] = '{4'h1, 4'h9, 4'h5, 4'h3, 4'hf};

   always #20 clk = ~clk;

   sss_top sss_top_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sample_request_irq_n(sample_request_irq_n), .irq(irq), .dac(dac));
   sss_dac_model sss_dac_model_inst (.clk(clk), .dac(dac), .left_word(left_word),
      .right_word(right_word));

   task automatic fail(input sss_word_t got, input sss_word_t exp);
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
   endtask
   task automatic chk_word(input sss_word_t got, input sss_word_t exp);
      n_checks++;
      if (got !== exp) fail(got, exp);
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) fail({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input sss_word_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input sss_word_t exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk_word(reg_rdata, exp);
   endtask
   task automatic wait_req();
      int k;
      k = 0;
      while (sample_request_irq_n !== 1'b0 && k < 8000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 8000) fail(32'h0000_0001, 32'h0000_0000);
      repeat (2) @(posedge clk);
   endtask
   // Host answers each request with one word; a frame leaves two requests later
   task automatic serve(input int count);
      for (int i = 0; i < count; i++) begin
         wait_req();
         chk_bit(irq, 1'b1);
         if (n_req >= 2) chk_word({left_word, right_word}, w2);
         w2 = w1;
         w1 = (n_req == 0) ? 32'h8000_0001 : (n_req == 1) ? 32'hffff_0000 : $random(seed);
         wr(`SSS_OFF_SAMPLE, w1);
         repeat (3) @(posedge clk);
         chk_bit(sample_request_irq_n, 1'b1);
         n_req++;
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      reset_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk_bit(sample_request_irq_n, 1'b1);
      rchk(`SSS_OFF_CTRL, 32'h0000_0000);
      rchk(`SSS_OFF_SAMPLE, 32'h0000_0000);
      rchk(8'h40, 32'h0000_0000);
      rv = $random(seed) & 32'hffff_fffe;
      wr(`SSS_OFF_CTRL, rv);
      rchk(`SSS_OFF_CTRL, {28'h000_0000, rv[3:0]});
      repeat (4000) @(posedge clk);
      chk_bit(dac.word_select_clock, 1'b0);
      chk_bit(sample_request_irq_n, 1'b1);
      $display("test reset and disable done");
      wr(`SSS_OFF_IRQ_EN, 32'h0000_0001);
      foreach (rates[i]) begin
         wr(`SSS_OFF_CTRL, {28'h000_0000, rates[i]});
         rchk(`SSS_OFF_CTRL, {28'h000_0000, rates[i]});
         serve(4);
         $display("test rate %h done", rates[i]);
      end
      wr(`SSS_OFF_IRQ_EN, 32'h0000_0000);
      wait_req();
      chk_bit(irq, 1'b0);
      repeat (700) @(posedge clk);
      rchk(`SSS_OFF_IRQ_STAT, 32'h0000_0003);
      wr(`SSS_OFF_IRQ_EN, 32'h0000_0002);
      @(negedge clk);
      chk_bit(irq, 1'b1);
      wr(`SSS_OFF_IRQ_CLR, 32'h0000_0003);
      repeat (3) @(posedge clk);
      chk_bit(irq, 1'b0);
      chk_bit(sample_request_irq_n, 1'b1);
      wr(`SSS_OFF_CTRL, 32'h0000_0000);
      repeat (10) @(posedge clk);
      chk_bit(dac.word_select_clock, 1'b0);
      $display("test interrupts and stop done");
      print_verdict();
   end

   // Run needs about 40k cycles; twice that means a hang
   initial begin
      repeat (80000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
endmodule // tb

bind sss_top sss_top_properties #(.CLK_HZ(CLK_HZ), .BIT_HZ(BIT_HZ)) sss_top_properties_inst (
   .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .sample_request_irq_n(sample_request_irq_n), .irq(irq), .dac(dac));
